/* verilog/lpc_core.sv */
// instruction execution core of the low power coprocessor
// assumes memory and peripherals answer a held request with one ack pulse
//
// Contract
// - four sixteen-bit registers, any may be operand or destination.
// - relative compare branches compare register zero.
// - load and store addresses are word indices, zero is first word.
// - store address is address register plus offset field.
// - stored word holds instruction address, constant one, register value.
// - load puts low sixteen bits of addressed word into destination.
// - halt stops execution but wakeup timer keeps running.
// - timer stop disables timer, execution continues.
// - branch less adds signed word offset when register zero below immediate.
// - branch ge adds offset when register zero at least immediate.
// - unconditional jump loads pc from register or immediate.
// - zero jump taken only when last alu result was zero.
// - overflow jump taken only when last alu operation overflowed.
// - register forms add, sub, and, or, move, shifts.
// - immediate forms of the same alu operations.
// - delay idles for operand cycles then proceeds.
// - peripheral write places literal into chosen bit range.
// - peripheral read puts chosen bit range into register zero.
// - each instruction is one 32-bit word, one fetch each.
// - wake does nothing unless controller ready, else signals interrupt.
`timescale 1ns/1ps
`default_nettype none
module lpc_core #(
  parameter logic [15:0] TIMER_CYCLES = lpc_pkg::TIMER_DEF
) (
  // clock, reset, enable
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic ce,
  // host start
  input wire logic start,
  input wire logic [10:0] entry_pc,
  output logic running,
  // slow memory
  output logic mem_req,
  output logic mem_we,
  output logic [15:0] mem_addr,
  output logic [31:0] mem_wdata,
  input wire logic mem_ack,
  input wire logic [31:0] mem_rdata,
  // peripheral registers
  output logic per_req,
  output logic per_we,
  output logic [8:0] per_addr,
  output logic [31:0] per_wdata,
  output logic [31:0] per_wmask,
  input wire logic per_ack,
  input wire logic [31:0] per_rdata,
  // wakeup to the low power controller
  input wire logic wake_ready,
  output logic wake_irq
);
  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_EXEC, ST_LOAD, ST_STORE, ST_PER, ST_DELAY, ST_HALT
  } lpc_state_t;

  typedef struct packed {
    lpc_state_t st;
    logic [10:0] pc;
    logic [10:0] entry;
    logic [31:0] ir;
    logic [3:0][15:0] gpr;
    logic zf;
    logic of;
    logic timer_en;
    logic [15:0] tcnt;
    logic [15:0] dcnt;
    logic mem_req;
    logic mem_we;
    logic [15:0] mem_addr;
    logic [31:0] mem_wdata;
    logic per_req;
    logic per_we;
    logic [8:0] per_addr;
    logic [31:0] per_wdata;
    logic [31:0] per_wmask;
    logic wake;
  } lpc_core_t;

  localparam lpc_core_t CORE_RST = '0;

  lpc_core_t s;
  lpc_core_t next_s;

  // ----------------------------------------------------------------
  // instruction fields
  // ----------------------------------------------------------------
  logic [4:0] opc;
  logic [1:0] rd;
  logic [1:0] rs;
  logic [1:0] rt;
  logic [15:0] imm;
  logic [7:0] boff;
  logic [10:0] pc_next;
  logic [10:0] br_tgt;
  logic [15:0] ls_addr;
  logic is_alu;
  logic [15:0] fld_ext;
  logic [31:0] fld_mask;
  logic [31:0] fld_wdata;

  assign opc = s.ir[lpc_pkg::OPC_HI:lpc_pkg::OPC_LO];
  assign rd = s.ir[lpc_pkg::RD_HI:lpc_pkg::RD_LO];
  assign rs = s.ir[lpc_pkg::RS_HI:lpc_pkg::RS_LO];
  assign rt = s.ir[lpc_pkg::RT_HI:lpc_pkg::RT_LO];
  assign imm = s.ir[lpc_pkg::IMM_HI:lpc_pkg::IMM_LO];
  assign boff = s.ir[lpc_pkg::BOFF_HI:lpc_pkg::BOFF_LO];
  assign pc_next = s.pc + lpc_pkg::PC_ONE;
  assign br_tgt = s.pc + {{3{boff[7]}}, boff};
  assign ls_addr = s.gpr[rs] + {5'h00, imm[lpc_pkg::PC_W-1:0]};
  assign is_alu = !opc[lpc_pkg::CTRL_BIT] && (opc[2:0] != lpc_pkg::ALU_NONE);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  lpc_alu_if alu_bus ();

  lpc_alu u_alu (
    .bus(alu_bus)
  );

  assign alu_bus.a = s.gpr[rs];
  assign alu_bus.b = opc[lpc_pkg::IMM_BIT] ? imm : s.gpr[rt];
  assign alu_bus.op = opc[2:0];

  lpc_field u_field (
    .low(s.ir[lpc_pkg::PLOW_HI:lpc_pkg::PLOW_LO]),
    .high(s.ir[lpc_pkg::PHIGH_HI:lpc_pkg::PHIGH_LO]),
    .rdata(per_rdata),
    .wval(s.ir[lpc_pkg::PDATA_HI:lpc_pkg::PDATA_LO]),
    .ext(fld_ext),
    .mask(fld_mask),
    .wdata(fld_wdata)
  );

  function automatic lpc_core_t go_fetch(input lpc_core_t c, input logic [10:0] a);
    lpc_core_t r;
    r = c;
    r.pc = a;
    r.st = ST_FETCH;
    r.mem_req = 1'b1;
    r.mem_we = 1'b0;
    r.mem_addr = {5'h00, a};
    return r;
  endfunction

  // ----------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------
  always_comb begin
    next_s = s;
    next_s.wake = 1'b0;
    unique case (s.st)
      ST_IDLE, ST_HALT: begin
        // start only from rest, so no bus request is ever cut short
        if (start) begin
          next_s = go_fetch(s, entry_pc);
          next_s.entry = entry_pc;
          next_s.timer_en = 1'b1;
          next_s.tcnt = 16'h0000;
        end else if (s.st == ST_HALT && s.timer_en) begin
          if (s.tcnt >= TIMER_CYCLES - lpc_pkg::CNT_ONE) begin
            next_s = go_fetch(s, s.entry);
            next_s.tcnt = 16'h0000;
          end else begin
            next_s.tcnt = s.tcnt + lpc_pkg::CNT_ONE;
          end
        end
      end
      ST_FETCH: begin
        if (mem_ack) begin
          next_s.mem_req = 1'b0;
          next_s.ir = mem_rdata;
          next_s.st = ST_EXEC;
        end
      end
      ST_EXEC: begin
        if (is_alu) begin
          next_s = go_fetch(s, pc_next);
          next_s.gpr[rd] = alu_bus.y;
          next_s.zf = alu_bus.zero;
          next_s.of = alu_bus.ovf;
        end else begin
          unique case (opc)
            lpc_pkg::STORE_OP: begin
              next_s.mem_req = 1'b1;
              next_s.mem_we = 1'b1;
              next_s.mem_addr = ls_addr;
              next_s.mem_wdata = {s.pc, lpc_pkg::STORE_TAG, s.gpr[rd]};
              next_s.st = ST_STORE;
            end
            lpc_pkg::LOAD_OP: begin
              next_s.mem_req = 1'b1;
              next_s.mem_we = 1'b0;
              next_s.mem_addr = ls_addr;
              next_s.st = ST_LOAD;
            end
            lpc_pkg::BRANCH_LESS_OP:
              next_s = go_fetch(s, (s.gpr[0] < imm) ? br_tgt : pc_next);
            lpc_pkg::BRANCH_GE_OP:
              next_s = go_fetch(s, (s.gpr[0] >= imm) ? br_tgt : pc_next);
            lpc_pkg::JUMP_REG_OP: next_s = go_fetch(s, s.gpr[rs][10:0]);
            lpc_pkg::JUMP_IMM_OP: next_s = go_fetch(s, imm[10:0]);
            lpc_pkg::JUMP_ZERO_REG_OP: next_s = go_fetch(s, s.zf ? s.gpr[rs][10:0] : pc_next);
            lpc_pkg::JUMP_ZERO_IMM_OP: next_s = go_fetch(s, s.zf ? imm[10:0] : pc_next);
            lpc_pkg::JUMP_OVF_REG_OP: next_s = go_fetch(s, s.of ? s.gpr[rs][10:0] : pc_next);
            lpc_pkg::JUMP_OVF_IMM_OP: next_s = go_fetch(s, s.of ? imm[10:0] : pc_next);
            lpc_pkg::HALT_OP: begin
              next_s.st = ST_HALT;
              next_s.tcnt = 16'h0000;
            end
            lpc_pkg::TIMER_STOP_OP: begin
              next_s = go_fetch(s, pc_next);
              next_s.timer_en = 1'b0;
            end
            lpc_pkg::DELAY_OP: begin
              if (imm == 16'h0000) begin
                next_s = go_fetch(s, pc_next);
              end else begin
                next_s.dcnt = imm - lpc_pkg::CNT_ONE;
                next_s.st = ST_DELAY;
              end
            end
            lpc_pkg::WAKE_OP: begin
              next_s = go_fetch(s, pc_next);
              next_s.wake = wake_ready;
            end
            lpc_pkg::PER_WRITE_OP: begin
              next_s.per_req = 1'b1;
              next_s.per_we = 1'b1;
              next_s.per_addr = s.ir[lpc_pkg::PADDR_HI:lpc_pkg::PADDR_LO];
              next_s.per_wdata = fld_wdata;
              next_s.per_wmask = fld_mask;
              next_s.st = ST_PER;
            end
            lpc_pkg::PER_READ_OP: begin
              next_s.per_req = 1'b1;
              next_s.per_we = 1'b0;
              next_s.per_addr = s.ir[lpc_pkg::PADDR_HI:lpc_pkg::PADDR_LO];
              next_s.st = ST_PER;
            end
            // unused codes run as no-operation
            default: next_s = go_fetch(s, pc_next);
          endcase
        end
      end
      ST_LOAD: begin
        if (mem_ack) begin
          next_s = go_fetch(s, pc_next);
          next_s.gpr[rd] = mem_rdata[15:0];
        end
      end
      ST_STORE: begin
        if (mem_ack) begin
          next_s = go_fetch(s, pc_next);
        end
      end
      ST_PER: begin
        if (per_ack) begin
          next_s = go_fetch(s, pc_next);
          next_s.per_req = 1'b0;
          if (!s.per_we) begin
            next_s.gpr[0] = fld_ext;
          end
        end
      end
      ST_DELAY: begin
        if (s.dcnt == 16'h0000) begin
          next_s = go_fetch(s, pc_next);
        end else begin
          next_s.dcnt = s.dcnt - lpc_pkg::CNT_ONE;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (!nrst) begin
      s <= CORE_RST;
    end else if (ce) begin
      s <= next_s;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign running = (s.st != ST_IDLE) && (s.st != ST_HALT);
  assign mem_req = s.mem_req;
  assign mem_we = s.mem_we;
  assign mem_addr = s.mem_addr;
  assign mem_wdata = s.mem_wdata;
  assign per_req = s.per_req;
  assign per_we = s.per_we;
  assign per_addr = s.per_addr;
  assign per_wdata = s.per_wdata;
  assign per_wmask = s.per_wmask;
  assign wake_irq = s.wake;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!nrst || !ce);

  logic ex;
  assign ex = (s.st == ST_EXEC);

  sequence halt_s;
    ex && !is_alu && opc == lpc_pkg::HALT_OP;
  endsequence
  sequence delay3_s;
    ex && !is_alu && opc == lpc_pkg::DELAY_OP && imm == 16'h0003;
  endsequence

  halt_stop_a: assert property (halt_s |=> s.st == ST_HALT && s.timer_en == $past(s.timer_en))
    else $error("halt did not stop the core");
  timer_stop_a: assert property (ex && !is_alu && opc == lpc_pkg::TIMER_STOP_OP
    |=> !s.timer_en && s.st == ST_FETCH && s.pc == $past(pc_next))
    else $error("timer stop wrong");
  store_word_a: assert property (ex && !is_alu && opc == lpc_pkg::STORE_OP
    |=> mem_we && mem_wdata[31:21] == $past(s.pc) && mem_wdata[20:16] == lpc_pkg::STORE_TAG
    && mem_addr == $past(ls_addr))
    else $error("store word malformed");
  load_low_a: assert property (s.st == ST_LOAD && mem_ack
    |=> s.gpr[$past(rd)] == $past(mem_rdata[15:0]) && s.st == ST_FETCH)
    else $error("load result wrong");
  less_branch_a: assert property (ex && !is_alu && opc == lpc_pkg::BRANCH_LESS_OP
    |=> s.pc == ($past(s.gpr[0] < imm) ? $past(br_tgt) : $past(pc_next)))
    else $error("branch less target wrong");
  ge_branch_a: assert property (ex && !is_alu && opc == lpc_pkg::BRANCH_GE_OP
    |=> s.pc == ($past(s.gpr[0] >= imm) ? $past(br_tgt) : $past(pc_next)))
    else $error("branch ge target wrong");
  zero_jump_a: assert property (ex && !is_alu && !s.zf && opc == lpc_pkg::JUMP_ZERO_IMM_OP
    |=> s.pc == $past(pc_next))
    else $error("zero jump taken without zero");
  ovf_jump_a: assert property (ex && !is_alu && s.of && opc == lpc_pkg::JUMP_OVF_IMM_OP
    |=> s.pc == $past(imm[10:0]))
    else $error("overflow jump not taken");
  wake_gate_a: assert property (wake_irq |-> $past(wake_ready) && $past(opc) == lpc_pkg::WAKE_OP)
    else $error("wake without ready");
  alu_flags_a: assert property (is_alu && ex
    |=> s.zf == (s.gpr[$past(rd)] == 16'h0000) && s.of == $past(alu_bus.ovf))
    else $error("alu flags not updated");
  delay_len_a: assert property (delay3_s |=> (s.st == ST_DELAY) [*3] ##1 s.st == ST_FETCH)
    else $error("delay length wrong");
  per_read_a: assert property (s.st == ST_PER && per_ack && !per_we
    |=> s.gpr[0] == $past(fld_ext))
    else $error("peripheral read into register zero wrong");
endmodule
`default_nettype wire

/* verilog/lpc_pkg.sv */
// constants shared by the coprocessor core and its helpers
// assumes one 32-bit instruction per memory word
package lpc_pkg;
  // ----------------------------------------------------------------
  // sizes
  // ----------------------------------------------------------------
  localparam int GPR_N = 4;
  localparam int DATA_W = 16;
  localparam int PC_W = 11;
  localparam int MEM_AW = 16;
  localparam int PER_AW = 9;
  localparam int WORD_W = 32;
  // ----------------------------------------------------------------
  // instruction fields
  // ----------------------------------------------------------------
  localparam int OPC_HI = 31;
  localparam int OPC_LO = 27;
  localparam int RD_HI = 26;
  localparam int RD_LO = 25;
  localparam int RS_HI = 24;
  localparam int RS_LO = 23;
  localparam int RT_HI = 22;
  localparam int RT_LO = 21;
  localparam int BOFF_HI = 23;
  localparam int BOFF_LO = 16;
  localparam int IMM_HI = 15;
  localparam int IMM_LO = 0;
  localparam int PDATA_HI = 26;
  localparam int PDATA_LO = 19;
  localparam int PHIGH_HI = 18;
  localparam int PHIGH_LO = 14;
  localparam int PLOW_HI = 13;
  localparam int PLOW_LO = 9;
  localparam int PADDR_HI = 8;
  localparam int PADDR_LO = 0;
  localparam int STPC_LO = 21;
  localparam int STTAG_LO = 16;
  localparam logic [4:0] STORE_TAG = 5'h01;
  // ----------------------------------------------------------------
  // alu selects, low three opcode bits; bit 3 picks the immediate
  // ----------------------------------------------------------------
  localparam logic [2:0] ALU_ADD = 3'h0;
  localparam logic [2:0] ALU_SUB = 3'h1;
  localparam logic [2:0] ALU_AND = 3'h2;
  localparam logic [2:0] ALU_OR = 3'h3;
  localparam logic [2:0] ALU_MOV = 3'h4;
  localparam logic [2:0] ALU_SHL = 3'h5;
  localparam logic [2:0] ALU_SHR = 3'h6;
  localparam logic [2:0] ALU_NONE = 3'h7;
  localparam int IMM_BIT = 3;
  localparam int CTRL_BIT = 4;
  // ----------------------------------------------------------------
  // control opcodes
  // ----------------------------------------------------------------
  localparam logic [4:0] STORE_OP = 5'h10;
  localparam logic [4:0] LOAD_OP = 5'h11;
  localparam logic [4:0] BRANCH_LESS_OP = 5'h12;
  localparam logic [4:0] BRANCH_GE_OP = 5'h13;
  localparam logic [4:0] JUMP_REG_OP = 5'h14;
  localparam logic [4:0] JUMP_IMM_OP = 5'h15;
  localparam logic [4:0] JUMP_ZERO_REG_OP = 5'h16;
  localparam logic [4:0] JUMP_ZERO_IMM_OP = 5'h17;
  localparam logic [4:0] JUMP_OVF_REG_OP = 5'h18;
  localparam logic [4:0] JUMP_OVF_IMM_OP = 5'h19;
  localparam logic [4:0] HALT_OP = 5'h1a;
  localparam logic [4:0] TIMER_STOP_OP = 5'h1b;
  localparam logic [4:0] DELAY_OP = 5'h1c;
  localparam logic [4:0] WAKE_OP = 5'h1d;
  localparam logic [4:0] PER_WRITE_OP = 5'h1e;
  localparam logic [4:0] PER_READ_OP = 5'h1f;
  localparam logic [PC_W-1:0] PC_ONE = 11'h001;
  localparam logic [15:0] CNT_ONE = 16'h0001;
  localparam logic [15:0] TIMER_DEF = 16'h03e8;
endpackage

/* verilog/lpc_alu_if.sv */
// operand and result bundle between the core and its alu
// assumes a purely combinational alu
`timescale 1ns/1ps
`default_nettype none
interface lpc_alu_if;
  logic [15:0] a;
  logic [15:0] b;
  logic [2:0] op;
  logic [15:0] y;
  logic zero;
  logic ovf;
  modport core (output a, output b, output op, input y, input zero, input ovf);
  modport alu (input a, input b, input op, output y, output zero, output ovf);
endinterface
`default_nettype wire

/* verilog/lpc_alu.sv */
// sixteen-bit alu of the coprocessor
// assumes the core registers result and flags
`timescale 1ns/1ps
`default_nettype none
module lpc_alu (
  // operands and result
  lpc_alu_if.alu bus
);
  logic [16:0] wide;

  // ----------------------------------------------------------------
  // datapath
  // ----------------------------------------------------------------
  // overflow is the carry out of add and the borrow of subtract
  always_comb begin
    wide = 17'h00000;
    unique case (bus.op)
      lpc_pkg::ALU_ADD: wide = {1'b0, bus.a} + {1'b0, bus.b};
      lpc_pkg::ALU_SUB: wide = {1'b0, bus.a} - {1'b0, bus.b};
      lpc_pkg::ALU_AND: wide = {1'b0, bus.a & bus.b};
      lpc_pkg::ALU_OR: wide = {1'b0, bus.a | bus.b};
      lpc_pkg::ALU_MOV: wide = {1'b0, bus.b};
      lpc_pkg::ALU_SHL: wide = {1'b0, bus.a << bus.b};
      lpc_pkg::ALU_SHR: wide = {1'b0, bus.a >> bus.b};
      default: wide = 17'h00000;
    endcase
  end

  assign bus.y = wide[15:0];
  assign bus.zero = (wide[15:0] == 16'h0000);
  assign bus.ovf = wide[16];
endmodule
`default_nettype wire

/* verilog/lpc_field.sv */
// bit-range extract and masked-write shaping for peripheral words
// assumes low <= high; the range is clipped to sixteen bits on read
`timescale 1ns/1ps
`default_nettype none
module lpc_field (
  // range
  input wire logic [4:0] low,
  input wire logic [4:0] high,
  // data
  input wire logic [31:0] rdata,
  input wire logic [7:0] wval,
  output logic [15:0] ext,
  output logic [31:0] mask,
  output logic [31:0] wdata
);
  logic [5:0] width;
  logic [32:0] ones;
  logic [31:0] shifted;

  assign width = 6'({1'b0, high} - {1'b0, low} + 6'h01);
  assign ones = (33'h000000001 << width) - 33'h000000001;
  assign mask = ones[31:0] << low;
  assign shifted = (rdata & mask) >> low;
  assign ext = shifted[15:0];
  assign wdata = ({24'h000000, wval} << low) & mask;
endmodule
`default_nettype wire

/* test/lpc_mem_model.sv */
// slow memory and peripheral registers on the far side of the core
// assumes the core holds each request until it samples the ack
`timescale 1ns/1ps
`default_nettype none
module lpc_mem_model (
  // clock, reset, pacing
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic slow,
  // slow memory
  input wire logic mem_req,
  input wire logic mem_we,
  input wire logic [15:0] mem_addr,
  input wire logic [31:0] mem_wdata,
  output logic mem_ack,
  output logic [31:0] mem_rdata,
  // peripheral registers
  input wire logic per_req,
  input wire logic per_we,
  input wire logic [8:0] per_addr,
  input wire logic [31:0] per_wdata,
  input wire logic [31:0] per_wmask,
  output logic per_ack,
  output logic [31:0] per_rdata
);
  logic [31:0] words [0:255];
  logic [31:0] regs [0:15];
  logic [1:0] gap;
  // ----------------------------------------------------------------
  // answers
  // ----------------------------------------------------------------
  // data outside the ack toggles so stale reads cannot pass
  // one word per fetch
  assign mem_rdata = mem_ack ? words[mem_addr[7:0]] : {16{ref_clk, ~ref_clk}};
  assign per_rdata = per_ack ? regs[per_addr[3:0]] : {16{~ref_clk, ref_clk}};
  always @(posedge ref_clk) begin
    if (!nrst) begin
      mem_ack <= 1'b0;
      per_ack <= 1'b0;
      gap <= 2'h0;
    end else begin
      mem_ack <= 1'b0;
      per_ack <= 1'b0;
      if ((mem_req && !mem_ack) || (per_req && !per_ack)) begin
        gap <= gap + 2'h1;
        if (!slow || gap == 2'h2) begin
          gap <= 2'h0;
          mem_ack <= mem_req;
          per_ack <= per_req;
        end
      end
      if (mem_ack && mem_we) words[mem_addr[7:0]] <= mem_wdata;
      if (per_ack && per_we)
        regs[per_addr[3:0]] <= (regs[per_addr[3:0]] & ~per_wmask) | per_wdata;
    end
  end
endmodule
`default_nettype wire

/* test/low_power_coprocessor_core_bench.sv */
// self-checking bench: programs are loaded into the memory model and run
// assumes a short halt-to-restart wait so timer restarts stay quick
`timescale 1ns/1ps
`default_nettype none
module low_power_coprocessor_core_bench;
  logic ref_clk = 1'b0, nrst = 1'b0, ce = 1'b1, start = 1'b0, wake_ready = 1'b0, slow = 1'b0;
  logic [10:0] entry_pc = 11'h000;
  logic running, mem_req, mem_we, mem_ack, per_req, per_we, per_ack, wake_irq;
  logic [15:0] mem_addr;
  logic [8:0] per_addr;
  logic [31:0] mem_wdata, mem_rdata, per_wdata, per_wmask, per_rdata;
  int n_mismatch = 0, compares = 0, pa = 0, wakes = 0, w0 = 0;
  lpc_core #(.TIMER_CYCLES(16'h0004)) dut (.ref_clk(ref_clk), .nrst(nrst), .ce(ce),
    .start(start), .entry_pc(entry_pc), .running(running), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .per_req(per_req), .per_we(per_we), .per_addr(per_addr),
    .per_wdata(per_wdata), .per_wmask(per_wmask), .per_ack(per_ack),
    .per_rdata(per_rdata), .wake_ready(wake_ready), .wake_irq(wake_irq));
  lpc_mem_model mem (.ref_clk(ref_clk), .nrst(nrst), .slow(slow), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_ack(mem_ack),
    .mem_rdata(mem_rdata), .per_req(per_req), .per_we(per_we), .per_addr(per_addr),
    .per_wdata(per_wdata), .per_wmask(per_wmask), .per_ack(per_ack),
    .per_rdata(per_rdata));
  initial forever #12.5 ref_clk = ~ref_clk;
  always @(posedge ref_clk) if (wake_irq === 1'b1) wakes <= wakes + 1;
  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] w(input logic [4:0] op, input logic [1:0] rd, rs, rt,
    input logic [15:0] imm);
    return {op, rd, rs, rt, 5'h00, imm};
  endfunction
  function automatic logic [31:0] br(input logic [4:0] op, input logic [7:0] off,
    input logic [15:0] imm);
    return {op, 3'h0, off, imm};
  endfunction
  function automatic logic [31:0] s(input logic [10:0] pc, input logic [15:0] v);
    return {pc, 5'h01, v};
  endfunction
  task put(input logic [31:0] x);
    mem.words[pa] = x;
    pa++;
  endtask
  task clear;
    for (int i = 0; i < 256; i++) mem.words[i] = 32'h0;
    pa = 0;
  endtask
  task chk(input string what, input logic [31:0] exp, got);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  // done once the core stays stopped longer than a timer restart
  task run;
    int quiet, n;
    @(posedge ref_clk);
    start <= 1'b1;
    @(posedge ref_clk);
    start <= 1'b0;
    quiet = 0;
    n = 0;
    while (quiet < 8 && n < 3000) begin
      @(posedge ref_clk);
      quiet = (running === 1'b0) ? quiet + 1 : 0;
      n++;
    end
    chk("core stopped", 32'h0, {31'h0, running});
  endtask
  task give_verdict;
    $display("compares %0d mismatches %0d", compares, n_mismatch);
    if (n_mismatch == 0 && compares > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // scenarios
  // ----------------------------------------------------------------
  task t_alu;
    clear;
    put(w(5'h0c, 3, 0, 0, 16'h0020));
    put(w(5'h0c, 1, 0, 0, 16'h00f0));
    put(w(5'h08, 2, 1, 0, 16'h0012));
    put(w(5'h10, 2, 3, 0, 16'h0000));
    put(w(5'h01, 0, 2, 1, 16'h0000));
    put(w(5'h10, 0, 3, 0, 16'h0001));
    put(w(5'h0d, 0, 1, 0, 16'h0004));
    put(w(5'h03, 0, 0, 2, 16'h0000));
    put(w(5'h10, 0, 3, 0, 16'h0002));
    put(w(5'h04, 1, 0, 2, 16'h0000));
    put(w(5'h0e, 1, 1, 0, 16'h0004));
    put(w(5'h0a, 1, 1, 0, 16'h0030));
    put(w(5'h10, 1, 3, 0, 16'h0003));
    put(w(5'h1b, 0, 0, 0, 16'h0000));
    put(w(5'h1a, 0, 0, 0, 16'h0000));
    run;
    chk("add imm store", s(11'd3, 16'h0102), mem.words[32]);
    chk("sub reg store", s(11'd5, 16'h0012), mem.words[33]);
    chk("shl or store", s(11'd8, 16'h0f02), mem.words[34]);
    chk("mov shr and store", s(11'd12, 16'h0010), mem.words[35]);
    $display("test alu done");
  endtask
  task t_branch;
    clear;
    slow <= 1'b1;
    mem.words[64] = 32'habcd_1234;
    put(w(5'h0c, 3, 0, 0, 16'h0010));
    put(w(5'h11, 1, 3, 0, 16'h0030));
    put(w(5'h10, 1, 3, 0, 16'h0040));
    put(w(5'h0c, 0, 0, 0, 16'h0005));
    put(w(5'h08, 0, 0, 0, 16'h0001));
    put(br(5'h12, 8'hff, 16'h0008));
    put(w(5'h10, 0, 3, 0, 16'h0041));
    put(br(5'h13, 8'h02, 16'h0008));
    put(w(5'h10, 0, 3, 0, 16'h0042));
    put(w(5'h1b, 0, 0, 0, 16'h0000));
    put(w(5'h1a, 0, 0, 0, 16'h0000));
    run;
    chk("load low half", s(11'd2, 16'h1234), mem.words[80]);
    chk("less loop count", s(11'd6, 16'h0008), mem.words[81]);
    chk("ge skip", 32'h0, mem.words[82]);
    slow <= 1'b0;
    $display("test branch done");
  endtask
  task t_jump;
    clear;
    put(w(5'h0c, 3, 0, 0, 16'h0060));
    put(w(5'h0c, 1, 0, 0, 16'h0000));
    put(w(5'h17, 0, 0, 0, 16'h0004));
    put(w(5'h10, 3, 1, 0, 16'h0061));
    put(w(5'h0c, 2, 0, 0, 16'hffff));
    put(w(5'h08, 2, 2, 0, 16'h0001));
    put(w(5'h19, 0, 0, 0, 16'h0008));
    put(w(5'h10, 3, 1, 0, 16'h0062));
    put(w(5'h08, 2, 2, 0, 16'h0001));
    put(w(5'h17, 0, 0, 0, 16'h000b));
    put(w(5'h10, 2, 1, 0, 16'h0063));
    put(w(5'h19, 0, 0, 0, 16'h000d));
    put(w(5'h10, 2, 1, 0, 16'h0064));
    put(w(5'h0c, 0, 0, 0, 16'h0010));
    put(w(5'h14, 0, 0, 0, 16'h0000));
    put(w(5'h10, 3, 1, 0, 16'h0065));
    put(w(5'h1d, 0, 0, 0, 16'h0000));
    put(w(5'h15, 0, 0, 0, 16'h0013));
    put(w(5'h10, 3, 1, 0, 16'h0066));
    put(w(5'h0c, 0, 0, 0, 16'h0018));
    put(w(5'h0c, 3, 0, 0, 16'h001b));
    put(w(5'h0c, 2, 0, 0, 16'h0000));
    put(w(5'h16, 0, 0, 0, 16'h0000));
    put(w(5'h10, 3, 1, 0, 16'h0067));
    put(w(5'h09, 2, 2, 0, 16'h0001));
    put(w(5'h18, 0, 3, 0, 16'h0000));
    put(w(5'h10, 3, 1, 0, 16'h0068));
    put(w(5'h1b, 0, 0, 0, 16'h0000));
    put(w(5'h1a, 0, 0, 0, 16'h0000));
    run;
    chk("taken jumps", 32'h0, mem.words[97] | mem.words[98] | mem.words[101]);
    chk("imm jump", 32'h0, mem.words[102]);
    chk("zero reg jump", 32'h0, mem.words[103]);
    chk("ovf reg jump", 32'h0, mem.words[104]);
    chk("zero not taken", s(11'd10, 16'h0001), mem.words[99]);
    chk("ovf not taken", s(11'd12, 16'h0001), mem.words[100]);
    chk("wake not ready", 32'h0, wakes);
    $display("test jump done");
  endtask
  task t_per_timer;
    clear;
    mem.regs[5] = 32'h0000_a5c3;
    wake_ready <= 1'b1;
    w0 = wakes;
    put({5'h1e, 8'h3c, 5'd15, 5'd8, 9'h005});
    put({5'h1f, 8'h00, 5'd11, 5'd4, 9'h005});
    put(w(5'h0c, 3, 0, 0, 16'h0000));
    put(w(5'h10, 0, 3, 0, 16'h0070));
    put(w(5'h1c, 0, 0, 0, 16'h0003));
    put(w(5'h1d, 0, 0, 0, 16'h0000));
    put(w(5'h11, 0, 3, 0, 16'h007f));
    put(w(5'h08, 0, 0, 0, 16'h0001));
    put(w(5'h10, 0, 3, 0, 16'h007f));
    put(br(5'h13, 8'h02, 16'h0003));
    put(w(5'h1a, 0, 0, 0, 16'h0000));
    put(w(5'h1b, 0, 0, 0, 16'h0000));
    put(w(5'h1a, 0, 0, 0, 16'h0000));
    run;
    chk("periph field write", 32'h0000_3cc3, mem.regs[5]);
    chk("periph field read", s(11'd3, 16'h00cc), mem.words[112]);
    chk("timer restarts", s(11'd8, 16'h0003), mem.words[127]);
    chk("wake pulses", 32'd3, wakes - w0);
    $display("test periph timer done");
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    nrst <= 1'b1;
    t_alu;
    t_branch;
    t_jump;
    t_per_timer;
    give_verdict;
  end
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_mismatch++;
    give_verdict;
  end
endmodule
`default_nettype wire
